// ==== ppsq_cfg.svh ====
`ifndef PPSQ_CFG_SVH
`define PPSQ_CFG_SVH

// ****************************************************************
// Core clock.
// ****************************************************************
`define PPSQ_CORE_CLK_MHZ    25
`define PPSQ_CORE_PERIOD_NS  40

// ****************************************************************
// Sequence lengths in phase detector or feedback clock cycles.
// ****************************************************************
`define PPSQ_REF_CYCLES      65536
`define PPSQ_FB_CYCLES       65536
`define PPSQ_CAL_CYCLES      131072
`define PPSQ_LOCK_MIN        2048
`define PPSQ_LOCK_MAX        2560
`define PPSQ_LOCK_CYCLES     2304

// ****************************************************************
// Feedback counter word and output enable reset value.
// ****************************************************************
`define PPSQ_FB_CW           6'h20
`define PPSQ_CW_IDLE         6'h00
`define PPSQ_N_OUT           8
`define PPSQ_OE_DEFAULT      8'hff

`endif

// ==== ppsq_pkg.sv ====
package ppsq_pkg;

  // ****************************************************************
  // Sequencer states.
  // ****************************************************************
  typedef enum logic [6:0] {
    PPSQ_ST_OFF    = 7'h01,
    PPSQ_ST_CRYSTAL_OSCILLATOR_INPUT   = 7'h02,
    PPSQ_ST_REF    = 7'h04,
    PPSQ_ST_FB     = 7'h08,
    PPSQ_ST_CAL    = 7'h10,
    PPSQ_ST_RUN    = 7'h20,
    PPSQ_ST_LOCKED = 7'h40
  } ppsq_state_t;

  // ****************************************************************
  // Pin levels and reported status.
  // ****************************************************************
  typedef struct packed {
    logic por_ok;
    logic hard_reset_low_pin_n;
    logic power_down_low_pin_n;
    logic crystal_oscillator_input_swing_ok;
    logic crystal_oscillator_input_used;
    logic cal_fail;
  } ppsq_pins_t;

  typedef struct packed {
    logic outputs_on;
    logic locked;
    logic cal_active;
    logic cal_failed;
  } ppsq_status_t;

endpackage : ppsq_pkg

// ==== ppsq_sync.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Two flop synchroniser with a rising edge pulse per bit.
// ****************************************************************
module ppsq_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;

endmodule : ppsq_sync

// ==== ppsq_sequencer.sv ====
`timescale 1ns/1ns
`include "ppsq_cfg.svh"

module ppsq_sequencer #(
  parameter int unsigned N_OUT       = `PPSQ_N_OUT,
  parameter int unsigned CNT_W       = 18,
  parameter int unsigned REF_CYCLES  = `PPSQ_REF_CYCLES,
  parameter int unsigned FB_CYCLES   = `PPSQ_FB_CYCLES,
  parameter int unsigned CAL_CYCLES  = `PPSQ_CAL_CYCLES,
  parameter int unsigned LOCK_CYCLES = `PPSQ_LOCK_CYCLES
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     nrst_i,
  input  wire ppsq_pkg::ppsq_pins_t     pins_i,
  input  wire logic                     phase_detector_clk_i,
  input  wire logic                     feedback_divided_clock_i,
  input  wire logic [N_OUT-1:0]         output_supply_rail_ok_i,
  input  wire logic                     oe_wr_i,
  input  wire logic [$clog2(N_OUT)-1:0] oe_sel_i,
  input  wire logic                     oe_val_i,
  input  wire logic                     lock_on_status_zero_i,
  input  wire logic                     lock_on_status_one_i,
  output logic      [N_OUT-1:0]         out_en_o,
  output logic                          status_pin_zero_o,
  output logic                          status_pin_one_o,
  output logic      [5:0]               counter_word_setting_o,
  output ppsq_pkg::ppsq_status_t        status_o
);

  import ppsq_pkg::*;

  // ****************************************************************
  // Input synchronisation.
  // ****************************************************************
  ppsq_pins_t       pins_s;
  logic [N_OUT-1:0] supply_s;
  logic [1:0]       clk_rise;
  logic             ref_tick;
  logic             fb_tick;
  logic             run_ok;

  ppsq_sync #(
    .W ($bits(ppsq_pins_t) + N_OUT)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    ({pins_i, output_supply_rail_ok_i}),
    .level_o    ({pins_s, supply_s}),
    .rise_o     ()
  );

  // The sampled clocks must run below half the core clock rate.
  ppsq_sync #(
    .W (2)
  ) u_clk_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    ({phase_detector_clk_i, feedback_divided_clock_i}),
    .level_o    (),
    .rise_o     (clk_rise)
  );

  assign ref_tick = clk_rise[1];
  assign fb_tick  = clk_rise[0];

  // Any of the three release conditions dropping acts as a full reset.
  assign run_ok = pins_s.por_ok
                & pins_s.hard_reset_low_pin_n
                & pins_s.power_down_low_pin_n;

  // ****************************************************************
  // Counter helpers.
  // ****************************************************************
  function automatic logic cnt_last(input logic [CNT_W-1:0] c, input int unsigned lim);
    return c == CNT_W'(lim - 1);
  endfunction : cnt_last

  function automatic logic st_on(input ppsq_state_t s);
    return (s == PPSQ_ST_RUN) || (s == PPSQ_ST_LOCKED);
  endfunction : st_on

  // ****************************************************************
  // Sequencer state machine.
  // ****************************************************************
  ppsq_state_t      state_q;
  ppsq_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             failed_q;
  logic             failed_d;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    failed_d = failed_q;
    if (!run_ok) begin
      state_d  = PPSQ_ST_OFF;
      cnt_d    = '0;
      failed_d = 1'b0;
    end else begin
      case (state_q)
        PPSQ_ST_OFF: begin
          state_d = PPSQ_ST_CRYSTAL_OSCILLATOR_INPUT;
        end
        PPSQ_ST_CRYSTAL_OSCILLATOR_INPUT: begin
          if (!pins_s.crystal_oscillator_input_used || pins_s.crystal_oscillator_input_swing_ok) begin
            state_d = PPSQ_ST_REF;
            cnt_d   = '0;
          end
        end
        PPSQ_ST_REF: begin
          if (ref_tick) begin
            if (cnt_last(cnt_q, REF_CYCLES)) begin
              state_d = PPSQ_ST_FB;
              cnt_d   = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        PPSQ_ST_FB: begin
          if (fb_tick) begin
            if (cnt_last(cnt_q, FB_CYCLES)) begin
              state_d = PPSQ_ST_CAL;
              cnt_d   = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        PPSQ_ST_CAL: begin
          if (failed_q || pins_s.cal_fail) begin
            failed_d = 1'b1;
          end else if (ref_tick) begin
            if (cnt_last(cnt_q, CAL_CYCLES)) begin
              state_d = PPSQ_ST_RUN;
              cnt_d   = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        PPSQ_ST_RUN: begin
          if (ref_tick) begin
            if (cnt_last(cnt_q, LOCK_CYCLES)) begin
              state_d = PPSQ_ST_LOCKED;
              cnt_d   = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        PPSQ_ST_LOCKED: begin
          state_d = PPSQ_ST_LOCKED;
        end
        default: begin
          state_d = PPSQ_ST_OFF;
          cnt_d   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q  <= PPSQ_ST_OFF;
      cnt_q    <= '0;
      failed_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      failed_q <= failed_d;
    end
  end

  // ****************************************************************
  // Output enable register, written one bit at a time.
  // ****************************************************************
  logic [N_OUT-1:0] oe_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_q <= N_OUT'(`PPSQ_OE_DEFAULT);
    end else if (!run_ok) begin
      oe_q <= N_OUT'(`PPSQ_OE_DEFAULT);
    end else if (oe_wr_i) begin
      oe_q[oe_sel_i] <= oe_val_i;
    end
  end

  // ****************************************************************
  // Registered outputs, driven from the next state.
  // ****************************************************************
  logic lock_d;

  assign lock_d = (state_d == PPSQ_ST_LOCKED);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_en_o               <= '0;
      status_pin_zero_o      <= 1'b0;
      status_pin_one_o       <= 1'b0;
      counter_word_setting_o <= `PPSQ_CW_IDLE;
      status_o               <= '0;
    end else begin
      out_en_o <= st_on(state_d) ? (oe_q & supply_s) : '0;
      status_pin_zero_o      <= lock_on_status_zero_i & lock_d;
      status_pin_one_o       <= lock_on_status_one_i & lock_d;
      counter_word_setting_o <= (state_d == PPSQ_ST_FB) ? `PPSQ_FB_CW : `PPSQ_CW_IDLE;
      status_o.outputs_on    <= st_on(state_d);
      status_o.locked        <= lock_d;
      status_o.cal_active    <= (state_d == PPSQ_ST_CAL);
      status_o.cal_failed    <= failed_d;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  localparam int LOCK_MIN = `PPSQ_LOCK_MIN;
  localparam int LOCK_MAX = `PPSQ_LOCK_MAX;

  logic [11:0] lock_age_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_age_q <= '0;
    end else if (state_q != PPSQ_ST_RUN) begin
      lock_age_q <= '0;
    end else if (ref_tick && (lock_age_q != 12'hfff)) begin
      lock_age_q <= lock_age_q + 12'h001;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_por_holds_off: assert property (
    !pins_s.por_ok |=> (state_q == PPSQ_ST_OFF) && (out_en_o == '0))
    else $error("sequencer ran before power-on release");

  a_pins_gate_seq: assert property (
    (state_q != PPSQ_ST_OFF) |-> $past(run_ok))
    else $error("sequencer advanced with a control pin low");

  a_crystal_oscillator_input_wait: assert property (
    (state_q == PPSQ_ST_CRYSTAL_OSCILLATOR_INPUT) && run_ok && pins_s.crystal_oscillator_input_used && !pins_s.crystal_oscillator_input_swing_ok
      |=> (state_q == PPSQ_ST_CRYSTAL_OSCILLATOR_INPUT))
    else $error("left crystal wait without sufficient swing");

  a_ref_before_fb: assert property (
    $rose(state_q == PPSQ_ST_FB) |-> $past(state_q == PPSQ_ST_REF) && $past(ref_tick)
      && ($past(cnt_q) == CNT_W'(REF_CYCLES - 1)))
    else $error("feedback count began before reference count ended");

  a_fb_word: assert property (
    (state_q == PPSQ_ST_FB) |-> (counter_word_setting_o == `PPSQ_FB_CW))
    else $error("feedback counter word not 32 during feedback count");

  a_cal_length: assert property (
    $rose(state_q == PPSQ_ST_RUN) |-> $past(state_q == PPSQ_ST_CAL)
      && ($past(cnt_q) == CNT_W'(CAL_CYCLES - 1)) && $past(ref_tick))
    else $error("calibration did not last the full count");

  a_out_on_next: assert property (
    $rose(state_q == PPSQ_ST_RUN) |-> status_o.outputs_on
      && (out_en_o == ($past(oe_q) & $past(supply_s))))
    else $error("outputs did not turn on right after calibration");

  a_lock_window: assert property (
    $rose(state_q == PPSQ_ST_LOCKED) |-> (lock_age_q >= 12'(LOCK_MIN))
      && (lock_age_q <= 12'(LOCK_MAX)))
    else $error("lock raised outside its cycle window");

  a_pdn_all_off: assert property (
    !pins_s.power_down_low_pin_n |=> (out_en_o == '0) && !status_pin_zero_o
      && !status_pin_one_o && (state_q == PPSQ_ST_OFF))
    else $error("output active during power-down");

  a_exit_defaults: assert property (
    !run_ok ##1 run_ok |-> (oe_q == N_OUT'(`PPSQ_OE_DEFAULT)) ##1 (state_q == PPSQ_ST_CRYSTAL_OSCILLATOR_INPUT))
    else $error("power-down exit did not restart from defaults");

  a_gate_enable: assert property (
    st_on(state_q) |-> (out_en_o == ($past(oe_q) & $past(supply_s))))
    else $error("output does not follow its enable bit");

  a_supply_gate: assert property (
    ((out_en_o & ~$past(supply_s)) == '0))
    else $error("output enabled without valid supply");

  a_fail_sticks: assert property (
    status_o.cal_failed && run_ok |=> status_o.cal_failed && !status_o.outputs_on)
    else $error("failed calibration cleared without pin toggle");

  a_lock_low: assert property (
    (state_q != PPSQ_ST_LOCKED) |-> !status_o.locked && !status_pin_zero_o && !status_pin_one_o)
    else $error("lock indicator high before lock");

  a_fb_clock_use: assert property (
    (state_q == PPSQ_ST_FB) && !fb_tick && run_ok |=> $stable(cnt_q))
    else $error("feedback count moved without a feedback clock edge");

endmodule : ppsq_sequencer

// ==== ppsq_host_model.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Board controller with reference and feedback clock sources.
// ****************************************************************
module ppsq_host_model (
  input  wire logic             core_clk_i,
  input  wire logic             por_ok_i,
  input  wire logic             pd_n_i,
  input  wire logic             swing_i,
  input  wire logic             crystal_oscillator_input_used_i,
  input  wire logic             cal_fail_i,
  output ppsq_pkg::ppsq_pins_t  pins_o,
  output logic                  ref_clk_o,
  output logic                  fb_clk_o
);
  import ppsq_pkg::*;

  logic [3:0] div_q  = 4'h0;
  logic       hr_n_q = 1'b1;

  // Reference runs at a quarter of the core rate, feedback at a twelfth.
  always @(posedge core_clk_i) begin
    div_q <= (div_q == 4'hb) ? 4'h0 : div_q + 4'h1;
  end

  assign ref_clk_o = div_q[1];
  assign fb_clk_o  = (div_q > 4'h5);

  // Both control pins stay high while the start-up sequence runs.
  assign pins_o = {por_ok_i, hr_n_q, pd_n_i, swing_i, crystal_oscillator_input_used_i, cal_fail_i};

  // Hard reset pin driven low for four cycles, then high again to re-run calibration.
  task automatic recal();
    @(posedge core_clk_i);
    hr_n_q <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    hr_n_q <= 1'b1;
  endtask : recal
endmodule : ppsq_host_model

// ==== tb.sv ====
`timescale 1ns/1ns

`include "ppsq_cfg.svh"

module tb;
  import ppsq_pkg::*;

  localparam int REF_DIV = 4;
  localparam int CAL_N   = 16;
  localparam int CAL_LO  = (CAL_N - 1) * REF_DIV + 1;
  localparam int CAL_HI  = CAL_N * REF_DIV;
  localparam int LOCK_LO = `PPSQ_LOCK_MIN * REF_DIV;
  localparam int LOCK_HI = `PPSQ_LOCK_MAX * REF_DIV;

  logic                 core_clk_i;
  logic                 nrst_i  = 1'b0;
  logic                 por     = 1'b0;
  logic                 pd_n    = 1'b1;
  logic                 swing   = 1'b0;
  logic                 xused   = 1'b1;
  logic                 cfail   = 1'b0;
  logic [7:0]           rail    = 8'h00;
  logic                 oe_wr   = 1'b0;
  logic [2:0]           oe_sel  = 3'h0;
  logic                 oe_val  = 1'b0;
  logic                 lk0     = 1'b0;
  logic                 lk1     = 1'b0;
  logic [7:0]           out_en;
  logic                 sp0;
  logic                 sp1;
  logic [5:0]           cw;
  ppsq_status_t         st;
  ppsq_pins_t           pins;
  logic                 refc;
  logic                 fbc;
  logic [19:0]          snap;
  logic [19:0]          prev    = 20'h0;
  logic [19:0]          expq[$];
  logic [31:0]          seed    = 32'h77da6bb6;
  logic [7:0]           oe_m;
  logic [7:0]           en_m;
  logic                 mon_on  = 1'b1;
  int                   failures = 0;
  int                   num_checks = 0;
  int                   cyc = 0;
  int                   ton = 0;
  int                   tcal = 0;
  int                   dt = 0;

  ppsq_host_model u_host (.core_clk_i(core_clk_i), .por_ok_i(por), .pd_n_i(pd_n),
    .swing_i(swing), .crystal_oscillator_input_used_i(xused), .cal_fail_i(cfail), .pins_o(pins),
    .ref_clk_o(refc), .fb_clk_o(fbc));

  ppsq_sequencer #(.REF_CYCLES(8), .FB_CYCLES(8), .CAL_CYCLES(CAL_N)) u_dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .pins_i(pins), .phase_detector_clk_i(refc),
    .feedback_divided_clock_i(fbc), .output_supply_rail_ok_i(rail), .oe_wr_i(oe_wr),
    .oe_sel_i(oe_sel), .oe_val_i(oe_val), .lock_on_status_zero_i(lk0),
    .lock_on_status_one_i(lk1), .out_en_o(out_en), .status_pin_zero_o(sp0),
    .status_pin_one_o(sp1), .counter_word_setting_o(cw), .status_o(st));

  assign snap = {out_en, sp0, sp1, cw, st};

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic drain(input int n);
    int i;
    i = 0;
    while (expq.size() != 0 && i < n) begin
      @(posedge core_clk_i);
      i++;
    end
    check(20'(expq.size()), 20'h0);
    expq.delete();
  endtask : drain

  task automatic wr(input logic [2:0] sel, input logic val);
    @(posedge core_clk_i);
    oe_wr  <= 1'b1;
    oe_sel <= sel;
    oe_val <= val;
    @(posedge core_clk_i);
    oe_wr  <= 1'b0;
  endtask : wr

  // Expected output changes of one full start-up run.
  task automatic seq(input logic [7:0] en, input logic a, input logic b);
    expq.push_back({8'h00, 2'b00, 6'h20, 4'b0000});
    expq.push_back({8'h00, 2'b00, 6'h00, 4'b0010});
    expq.push_back({en, 2'b00, 6'h00, 4'b1000});
    expq.push_back({en, a, b, 6'h00, 4'b1100});
  endtask : seq

  task final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // ****************************************************************
  // Output watcher.
  // ****************************************************************
  always @(posedge core_clk_i) begin
    cyc++;
    #1;
    if (mon_on && snap !== prev) begin
      check(snap, (expq.size() == 0) ? prev : expq.pop_front());
      if (snap[1] && !prev[1])
        tcal = cyc;
      if (snap[3] && !prev[3]) begin
        dt = cyc - tcal;
        check({19'h0, dt >= CAL_LO && dt <= CAL_HI}, 20'h1);
        ton = cyc;
      end
      if (snap[2] && !prev[2]) begin
        dt = cyc - ton;
        check({19'h0, dt >= LOCK_LO && dt <= LOCK_HI}, 20'h1);
      end
    end
    prev = snap;
  end

  always @(posedge core_clk_i) begin
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    core_clk_i = 1'b0;
    forever #(`PPSQ_CORE_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // Stimulus.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rail   <= 8'(rnd());
    lk0    <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    por <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    seq(rail, 1'b1, 1'b0);
    swing <= 1'b1;
    drain(12000);
    en_m = rail;
    oe_m = 8'hff;
    for (int i = 0; i < 8; i++) begin
      oe_m[i] = 1'(rnd());
      if ((oe_m & rail) !== en_m)
        expq.push_back({oe_m & rail, 2'b10, 6'h00, 4'b1100});
      en_m = oe_m & rail;
      wr(3'(i), oe_m[i]);
      drain(10);
    end
    if (oe_m !== en_m)
      expq.push_back({oe_m, 2'b10, 6'h00, 4'b1100});
    rail <= 8'hff;
    drain(10);
    expq.push_back(20'h0);
    pd_n <= 1'b0;
    drain(10);
    wr(3'h0, 1'b1);
    repeat (200) @(posedge core_clk_i);
    xused <= 1'b0;
    swing <= 1'b0;
    lk0   <= 1'b0;
    lk1   <= 1'b1;
    seq(8'hff, 1'b0, 1'b1);
    pd_n <= 1'b1;
    drain(12000);
    mon_on <= 1'b0;
    cfail  <= 1'b1;
    rail   <= 8'(rnd());
    u_host.recal();
    repeat (300) @(posedge core_clk_i);
    cfail <= 1'b0;
    repeat (100) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check({out_en, st.outputs_on, st.cal_failed, 10'h0}, {8'h00, 2'b01, 10'h0});
    u_host.recal();
    repeat (5) @(posedge core_clk_i);
    lk0    <= 1'b1;
    mon_on <= 1'b1;
    seq(rail, 1'b1, 1'b1);
    drain(12000);
    final_report();
  end
endmodule : tb
